//--- verilog/pfe_pkg.sv
package pfe_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0]  PFE_IDX_CAP_TWO    = 8'h5d;
	localparam logic [7:0]  PFE_IDX_EN_CTRL    = 8'h5f;
	localparam logic [7:0]  PFE_IDX_MASTER_EN  = 8'h59;
	localparam logic [31:0] PFE_ADDR_CAP_TWO   = {22'h0, PFE_IDX_CAP_TWO, 2'b00};
	localparam logic [31:0] PFE_ADDR_EN_CTRL   = {22'h0, PFE_IDX_EN_CTRL, 2'b00};

	// capacitor register layout
	localparam int          PFE_CAP_SEL_LSB    = 0;
	localparam int          PFE_CAP_SEL_W      = 5;
	localparam int          PFE_CAP_FACT_LSB   = 5;
	localparam int          PFE_CAP_FACT_W     = 2;
	localparam int          PFE_CAP_UNUSED_BIT = 7;
	localparam logic [7:0]  PFE_CAP_RESET      = 8'h27;
	localparam logic [7:0]  PFE_CAP_IMPL       = 8'h7f;
	localparam logic [4:0]  PFE_CAP_SEL_RESET  = 5'h07;
	localparam logic [4:0]  PFE_CAP_SEL_MIN    = 5'h00;
	localparam logic [4:0]  PFE_CAP_SEL_MAX    = 5'h1f;

	// enable register layout
	localparam int          PFE_EN_FACT_HI_LSB = 4;
	localparam int          PFE_EN_OUT_BIT     = 3;
	localparam int          PFE_EN_BIAS_BIT    = 2;
	localparam int          PFE_EN_FACT_LO_LSB = 0;
	localparam logic [7:0]  PFE_EN_RESET       = 8'hf1;
	localparam logic [7:0]  PFE_EN_IMPL        = 8'hff;
	localparam logic [5:0]  PFE_EN_FACT_RESET  = 6'h3d;

	// bus encodings
	localparam logic [1:0]  PFE_HTRANS_NONSEQ  = 2'b10;
	localparam logic        PFE_HRESP_OKAY     = 1'b0;

endpackage

//--- verilog/pfe_cfg_byte.sv
`timescale 1ns/100ps
module pfe_cfg_byte #(
	parameter logic [7:0] RST_VAL  = 8'h00,
	parameter logic [7:0] IMPL_MSK = 8'hff
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// write port
	input  wire logic       wr_en,
	input  wire logic [7:0] wdata,
	// register value and its next value
	output logic      [7:0] q,
	output logic      [7:0] d
);

	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_bit
			if (IMPL_MSK[b]) begin : g_impl
				logic bit_q;
				assign d[b] = wr_en ? wdata[b] : bit_q;
				always_ff @(posedge clk or negedge rst_n) begin
					if (!rst_n)
						bit_q <= RST_VAL[b];
					else
						bit_q <= d[b];
				end
				assign q[b] = bit_q;
			end else begin : g_void
				// unimplemented: reads zero, writes dropped
				assign d[b] = 1'b0;
				assign q[b] = 1'b0;
			end
		end
	endgenerate

	property p_void_bits_zero;
		@(posedge clk) disable iff (!rst_n)
		(q & ~IMPL_MSK) == 8'h00;
	endproperty
	a_void_bits_zero: assert property (p_void_bits_zero) else $error("unimplemented bit reads one");

	property p_hold_without_write;
		@(posedge clk) disable iff (!rst_n)
		!wr_en |=> q == $past(q);
	endproperty
	a_hold_without_write: assert property (p_hold_without_write) else $error("register moved without write");

endmodule

//--- verilog/pfe_out_gate.sv
`timescale 1ns/100ps
module pfe_out_gate (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// enables
	input  wire logic out_en,
	input  wire logic bias_en,
	input  wire logic master_en,
	// gated result
	output logic      active
);

	logic active_q;
	logic active_d;

	assign active_d = out_en & bias_en & master_en;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			active_q <= 1'b0;
		else
			active_q <= active_d;
	end

	assign active = active_q;

	property p_needs_all_three;
		@(posedge clk) disable iff (!rst_n)
		active |-> $past(out_en) && $past(bias_en) && $past(master_en);
	endproperty
	a_needs_all_three: assert property (p_needs_all_three) else $error("output active without all enables");

endmodule

//--- verilog/pfe_pll_filter_regs.sv
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps
// Notes on behaviour
// - the capacitor register holds a read/write 5-bit second-capacitor select in bits 4..0, reset to 00111.
// - the select code is passed on unchanged so the capacitance rises linearly from code 00000 to 11111.
// - factory bits reset to 0,1 in the capacitor register and to 1111 and 0,1 in the enable register.
// - enable register bit 3 enables the PLL output and bit 2 the PLL bias, 1 meaning enabled, both reset to 0.
// - the PLL output goes active one clock after output enable, bias enable and the master PLL enable are all set, and drops one clock after any clears.
module pfe_pll_filter_regs
	import pfe_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// master enable from the neighbouring register
	input  wire logic        pll_master_en,
	// loop filter and enable controls
	output logic [pfe_pkg::PFE_CAP_SEL_W-1:0] loop_cap_two_sel,
	output logic [pfe_pkg::PFE_CAP_FACT_W-1:0] cap_factory_reserved_bits,
	output logic [5:0]       en_factory_reserved_bits,
	output logic             pll_out_en,
	output logic             pll_bias_en,
	output logic             pll_out_active
);

	import pfe_pkg::*;

	// address phase decode
	wire        acc_take;
	wire        hit_cap;
	wire        hit_en;
	wire        rd_take;

	assign acc_take = hsel & hready & htrans[1];
	assign hit_cap  = (haddr == PFE_ADDR_CAP_TWO);
	assign hit_en   = (haddr == PFE_ADDR_EN_CTRL);
	assign rd_take  = acc_take & ~hwrite;

	// data phase state
	logic       dph_wr_cap_q;
	logic       dph_wr_en_q;
	logic       dph_wr_cap_d;
	logic       dph_wr_en_d;

	assign dph_wr_cap_d = acc_take & hwrite & hit_cap;
	assign dph_wr_en_d  = acc_take & hwrite & hit_en;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_wr_cap_q <= 1'b0;
			dph_wr_en_q  <= 1'b0;
		end else begin
			dph_wr_cap_q <= dph_wr_cap_d;
			dph_wr_en_q  <= dph_wr_en_d;
		end
	end

	// register storage
	wire [7:0] wr_byte;
	wire [7:0] cap_q;
	wire [7:0] cap_d;
	wire [7:0] en_q;
	wire [7:0] en_d;

	assign wr_byte = hwdata[7:0];

	pfe_cfg_byte #(
		.RST_VAL  (PFE_CAP_RESET),
		.IMPL_MSK (PFE_CAP_IMPL)
	) u_cap_two (
		.clk   (hclk),
		.rst_n (hresetn),
		.wr_en (dph_wr_cap_q),
		.wdata (wr_byte),
		.q     (cap_q),
		.d     (cap_d)
	);

	pfe_cfg_byte #(
		.RST_VAL  (PFE_EN_RESET),
		.IMPL_MSK (PFE_EN_IMPL)
	) u_en_ctrl (
		.clk   (hclk),
		.rst_n (hresetn),
		.wr_en (dph_wr_en_q),
		.wdata (wr_byte),
		.q     (en_q),
		.d     (en_d)
	);

	// field outputs straight from the storage flops
	assign loop_cap_two_sel          = cap_q[PFE_CAP_SEL_LSB +: PFE_CAP_SEL_W];
	assign cap_factory_reserved_bits = cap_q[PFE_CAP_FACT_LSB +: PFE_CAP_FACT_W];
	assign en_factory_reserved_bits  = {en_q[PFE_EN_FACT_HI_LSB +: 4], en_q[PFE_EN_FACT_LO_LSB +: 2]};
	assign pll_out_en                = en_q[PFE_EN_OUT_BIT];
	assign pll_bias_en               = en_q[PFE_EN_BIAS_BIT];

	pfe_out_gate u_gate (
		.clk       (hclk),
		.rst_n     (hresetn),
		.out_en    (pll_out_en),
		.bias_en   (pll_bias_en),
		.master_en (pll_master_en),
		.active    (pll_out_active)
	);

	// read path uses next values so a read right behind a write sees the new data
	wire [7:0]  rd_byte;
	wire [31:0] rdata_d;

	assign rd_byte = hit_cap ? cap_d : (hit_en ? en_d : 8'h00);
	assign rdata_d = rd_take ? {24'h000000, rd_byte} : 32'h00000000;

	logic [31:0] rdata_q;
	logic        readyout_q;
	logic        resp_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rdata_q <= 32'h00000000;
		else
			rdata_q <= rdata_d;
	end

	// zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			readyout_q <= 1'b1;
			resp_q     <= PFE_HRESP_OKAY;
		end else begin
			readyout_q <= 1'b1;
			resp_q     <= PFE_HRESP_OKAY;
		end
	end

	assign hrdata    = rdata_q;
	assign hreadyout = readyout_q;
	assign hresp     = resp_q;

	// helper state for the checks below
	logic seen_cap_wr_q;
	logic seen_en_wr_q;
	logic rd_cap_q;
	logic rd_en_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seen_cap_wr_q <= 1'b0;
			seen_en_wr_q  <= 1'b0;
			rd_cap_q      <= 1'b0;
			rd_en_q       <= 1'b0;
		end else begin
			seen_cap_wr_q <= seen_cap_wr_q | dph_wr_cap_q;
			seen_en_wr_q  <= seen_en_wr_q | dph_wr_en_q;
			rd_cap_q      <= rd_take & hit_cap;
			rd_en_q       <= rd_take & hit_en;
		end
	end

	property p_cap_reset_value;
		@(posedge hclk) disable iff (!hresetn)
		!seen_cap_wr_q && !dph_wr_cap_q |-> loop_cap_two_sel == PFE_CAP_SEL_RESET;
	endproperty
	a_cap_reset_value: assert property (p_cap_reset_value) else $error("capacitor select not at reset value");

	property p_cap_write_lands;
		@(posedge hclk) disable iff (!hresetn)
		dph_wr_cap_q |=> loop_cap_two_sel == $past(hwdata[4:0]) && cap_q[7] == 1'b0;
	endproperty
	a_cap_write_lands: assert property (p_cap_write_lands) else $error("capacitor write lost or bit 7 set");

	property p_cap_code_linear;
		@(posedge hclk) disable iff (!hresetn)
		rd_cap_q && !dph_wr_cap_q |-> hrdata[4:0] == loop_cap_two_sel
			&& loop_cap_two_sel >= PFE_CAP_SEL_MIN && loop_cap_two_sel <= PFE_CAP_SEL_MAX;
	endproperty
	a_cap_code_linear: assert property (p_cap_code_linear) else $error("capacitor code differs from readback");

	property p_factory_reset;
		@(posedge hclk) disable iff (!hresetn)
		!seen_en_wr_q && !dph_wr_en_q && !seen_cap_wr_q && !dph_wr_cap_q |->
			en_factory_reserved_bits == PFE_EN_FACT_RESET
			&& cap_factory_reserved_bits == PFE_CAP_RESET[PFE_CAP_FACT_LSB +: PFE_CAP_FACT_W];
	endproperty
	a_factory_reset: assert property (p_factory_reset) else $error("factory bits not at reset value");

	property p_enables_reset;
		@(posedge hclk) disable iff (!hresetn)
		!seen_en_wr_q && !dph_wr_en_q |-> !pll_out_en && !pll_bias_en && !pll_out_active;
	endproperty
	a_enables_reset: assert property (p_enables_reset) else $error("enable set before any write");

	property p_enable_readback;
		@(posedge hclk) disable iff (!hresetn)
		rd_en_q && !dph_wr_en_q |-> hrdata[3] == pll_out_en && hrdata[2] == pll_bias_en;
	endproperty
	a_enable_readback: assert property (p_enable_readback) else $error("enable readback wrong");

	property p_active_follows;
		@(posedge hclk) disable iff (!hresetn)
		pll_out_en && pll_bias_en && pll_master_en |=> pll_out_active;
	endproperty
	a_active_follows: assert property (p_active_follows) else $error("output not active with all enables");

	property p_active_drops;
		@(posedge hclk) disable iff (!hresetn)
		!pll_master_en ##1 !pll_master_en |-> !pll_out_active;
	endproperty
	a_active_drops: assert property (p_active_drops) else $error("output active without master enable");

	property p_bit7_reads_zero;
		@(posedge hclk) disable iff (!hresetn)
		rd_cap_q |-> hrdata[31:7] == 25'h0;
	endproperty
	a_bit7_reads_zero: assert property (p_bit7_reads_zero) else $error("capacitor bit 7 read as one");

	property p_no_wait;
		@(posedge hclk) disable iff (!hresetn)
		hreadyout && hresp == PFE_HRESP_OKAY;
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("slave inserted wait or error");

	property p_en_write_lands;
		@(posedge hclk) disable iff (!hresetn)
		dph_wr_en_q |=> pll_out_en == $past(hwdata[PFE_EN_OUT_BIT]) && pll_bias_en == $past(hwdata[PFE_EN_BIAS_BIT]);
	endproperty
	a_en_write_lands: assert property (p_en_write_lands) else $error("enable write lost");

	property p_cap_fact_write;
		@(posedge hclk) disable iff (!hresetn)
		dph_wr_cap_q |=> cap_factory_reserved_bits == $past(hwdata[PFE_CAP_FACT_LSB +: PFE_CAP_FACT_W]);
	endproperty
	a_cap_fact_write: assert property (p_cap_fact_write) else $error("capacitor factory bits not written");

	property p_en_fact_write;
		@(posedge hclk) disable iff (!hresetn)
		dph_wr_en_q |=> en_factory_reserved_bits == {$past(hwdata[7:4]), $past(hwdata[1:0])};
	endproperty
	a_en_fact_write: assert property (p_en_fact_write) else $error("enable factory bits not written");

	property p_cap_readback_full;
		@(posedge hclk) disable iff (!hresetn)
		rd_cap_q |-> hrdata[7:0] == cap_q;
	endproperty
	a_cap_readback_full: assert property (p_cap_readback_full) else $error("capacitor readback wrong");

	property p_en_readback_full;
		@(posedge hclk) disable iff (!hresetn)
		rd_en_q |-> hrdata[7:0] == en_q;
	endproperty
	a_en_readback_full: assert property (p_en_readback_full) else $error("enable register readback wrong");

	property p_upper_read_zero;
		@(posedge hclk) disable iff (!hresetn)
		rd_cap_q || rd_en_q |-> hrdata[31:8] == 24'h0;
	endproperty
	a_upper_read_zero: assert property (p_upper_read_zero) else $error("upper read data not zero");

	property p_idle_read_zero;
		@(posedge hclk) disable iff (!hresetn)
		!rd_cap_q && !rd_en_q |-> hrdata == 32'h0;
	endproperty
	a_idle_read_zero: assert property (p_idle_read_zero) else $error("read data outside a register read");

	property p_cap_kept_on_en_write;
		@(posedge hclk) disable iff (!hresetn)
		dph_wr_en_q |=> $stable(cap_q);
	endproperty
	a_cap_kept_on_en_write: assert property (p_cap_kept_on_en_write) else $error("capacitor moved on enable write");

	property p_en_kept_on_cap_write;
		@(posedge hclk) disable iff (!hresetn)
		dph_wr_cap_q |=> $stable(en_q);
	endproperty
	a_en_kept_on_cap_write: assert property (p_en_kept_on_cap_write) else $error("enables moved on capacitor write");

	property p_active_needs_out;
		@(posedge hclk) disable iff (!hresetn)
		!pll_out_en |=> !pll_out_active;
	endproperty
	a_active_needs_out: assert property (p_active_needs_out) else $error("output active without output enable");

	property p_active_needs_bias;
		@(posedge hclk) disable iff (!hresetn)
		!pll_bias_en |=> !pll_out_active;
	endproperty
	a_active_needs_bias: assert property (p_active_needs_bias) else $error("output active without bias enable");

	property p_active_rise;
		@(posedge hclk) disable iff (!hresetn)
		$rose(pll_out_active) |-> $past(pll_out_en) && $past(pll_bias_en) && $past(pll_master_en);
	endproperty
	a_active_rise: assert property (p_active_rise) else $error("output rose without all enables");

endmodule

//--- tb/pfe_ahb_master.sv
`timescale 1ns/100ps
module pfe_ahb_master
	import pfe_pkg::*;
(
	// clock
	input  wire logic        hclk,
	// ahb-lite master outputs
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	// slave answer
	input  wire logic [31:0] hrdata,
	input  wire logic        hready,
	// a wait used up its bound
	output logic             tmo
);
	initial begin
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0;
		tmo    = 1'b0;
	end

	// look at hready where it is settled, then move on at the edge that samples it
	task automatic wait_ready(output logic [31:0] dat);
		int n;
		n = 0;
		@(negedge hclk);
		while (hready !== 1'b1 && n < 64) begin
			@(negedge hclk);
			n++;
		end
		if (hready !== 1'b1)
			tmo <= 1'b1;
		dat = hrdata;
		@(posedge hclk);
	endtask

	// called just after a rising edge; leaves just after the edge ending the data phase
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		logic [31:0] unused;
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= PFE_HTRANS_NONSEQ;
		hwrite <= wr;
		hsize  <= 3'h2;
		wait_ready(unused);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= wd;
		wait_ready(rd);
	endtask
endmodule

//--- tb/pfe_pll_filter_regs_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("Error %0t: got %h expected %h", $time, (a), (b)); end end
module pfe_pll_filter_regs_tb;
	import pfe_pkg::*;
	logic        hclk          = 1'b0;
	logic        hresetn       = 1'b0;
	logic        pll_master_en = 1'b0;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        tmo;
	logic [4:0]  loop_cap_two_sel;
	logic [1:0]  cap_factory_reserved_bits;
	logic [5:0]  en_factory_reserved_bits;
	logic        pll_out_en;
	logic        pll_bias_en;
	logic        pll_out_active;
	logic [31:0] rd;
	logic [2:0]  c;
	logic [4:0]  codes [4] = '{5'h00, 5'h1f, 5'h0a, 5'h15};
	int          error_cnt = 0;
	int          n_checks  = 0;

	always #10 hclk = ~hclk;

	pfe_ahb_master i_pfe_ahb_master (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hready(hreadyout), .tmo(tmo));

	pfe_pll_filter_regs i_pfe_pll_filter_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pll_master_en(pll_master_en), .loop_cap_two_sel(loop_cap_two_sel),
		.cap_factory_reserved_bits(cap_factory_reserved_bits),
		.en_factory_reserved_bits(en_factory_reserved_bits), .pll_out_en(pll_out_en),
		.pll_bias_en(pll_bias_en), .pll_out_active(pll_out_active));

	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		i_pfe_ahb_master.xfer(1'b1, a, {24'h0, d}, rd);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
		i_pfe_ahb_master.xfer(1'b0, a, 32'h0, rd);
		`CHK(rd, {24'h0, exp})
		`CHK(hresp, PFE_HRESP_OKAY)
	endtask

	always @(posedge tmo) begin
		error_cnt++;
		test_done();
	end

	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK(loop_cap_two_sel, 5'h07)
		`CHK({cap_factory_reserved_bits, en_factory_reserved_bits}, 8'h7d)
		`CHK({pll_out_en, pll_bias_en, pll_out_active}, 3'b000)
		rd_chk(PFE_ADDR_CAP_TWO, 8'h27);
		rd_chk(PFE_ADDR_EN_CTRL, 8'hf1);
		// set bit 7 on purpose: it must not stick
		foreach (codes[k]) begin
			wr(PFE_ADDR_CAP_TWO, {1'b1, 2'b01, codes[k]});
			rd_chk(PFE_ADDR_CAP_TWO, {1'b0, 2'b01, codes[k]});
			`CHK(loop_cap_two_sel, codes[k])
		end
		// every combination of master, output and bias enable
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			wr(PFE_ADDR_EN_CTRL, {4'hf, c[1], c[0], 2'b01});
			pll_master_en <= c[2];
			repeat (2) @(posedge hclk);
			@(negedge hclk);
			`CHK(pll_out_active, &c)
			`CHK({pll_out_en, pll_bias_en}, c[1:0])
			@(posedge hclk);
			rd_chk(PFE_ADDR_EN_CTRL, {4'hf, c[1], c[0], 2'b01});
		end
		pll_master_en <= 1'b0;
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		`CHK(pll_out_active, 1'b0)
		@(posedge hclk);
		// unmapped word between the two registers
		wr(32'h178, 8'hff);
		rd_chk(32'h178, 8'h00);
		rd_chk(PFE_ADDR_CAP_TWO, 8'h35);
		// reset again in mid-run
		hresetn <= 1'b0;
		@(negedge hclk);
		`CHK({cap_factory_reserved_bits, en_factory_reserved_bits}, 8'h7d)
		`CHK(loop_cap_two_sel, 5'h07)
		`CHK({pll_out_en, pll_bias_en, pll_out_active}, 3'b000)
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(PFE_ADDR_EN_CTRL, 8'hf1);
		test_done();
	end
endmodule
